// >>> core/acg_regs.svh
`ifndef ACG_REGS_SVH
`define ACG_REGS_SVH

// Register offsets
`define ACG_OFF_SYN_EPR 7'h06
`define ACG_OFF_SYN_J 7'h07
`define ACG_OFF_SYN_DHI 7'h08
`define ACG_OFF_SYN_DLO 7'h09
`define ACG_OFF_SYN_PRE 7'h0A
`define ACG_OFF_P1_BSRC 7'h0B
`define ACG_OFF_P1_BDIV 7'h0C
`define ACG_OFF_P1_FDIV 7'h0D
`define ACG_OFF_P1_OSEL 7'h0E
`define ACG_OFF_GP_SRC 7'h15
`define ACG_OFF_GP_DIV 7'h16
`define ACG_OFF_P2_BSRC 7'h1B
`define ACG_OFF_P2_BDIV 7'h1C
`define ACG_OFF_P2_FDIV 7'h1D
`define ACG_OFF_P2_OSEL 7'h1E
`define ACG_OFF_P3_BSRC 7'h2B
`define ACG_OFF_P3_BDIV 7'h2C
`define ACG_OFF_P3_FDIV 7'h2D
`define ACG_OFF_P3_OSEL 7'h2E
`define ACG_OFF_PIN_PORT1_DATA_OUT_PIN 7'h43
`define ACG_OFF_PIN_FRM2 7'h45
`define ACG_OFF_PIN_BIT2 7'h46
`define ACG_OFF_PIN_GP_IO_PIN_ONE 7'h56
`define ACG_OFF_PIN_GP_IO_PIN_TWO 7'h57
`define ACG_OFF_PIN_GP_OUTPUT_PIN_ONE 7'h60

// Storage slots, in table order
`define ACG_NREG 25
`define ACG_IX_SYN_EPR 0
`define ACG_IX_SYN_J 1
`define ACG_IX_SYN_DHI 2
`define ACG_IX_SYN_DLO 3
`define ACG_IX_SYN_PRE 4
`define ACG_IX_GP_SRC 9
`define ACG_IX_GP_DIV 10
`define ACG_IX_PIN0 19

// Reset values
`define ACG_RST_SYN_EPR 8'h11
`define ACG_RST_SYN_J 8'h04
`define ACG_RST_SYN_PRE 8'h01
`define ACG_RST_ZERO 8'h00

// Common fields
`define ACG_EN_BIT 7
`define ACG_RATIO_MSB 6
`define ACG_DIV_MAX 8'h80
`define ACG_FDIV_MIN 8'h20
`define ACG_ONE 8'h01

// Synthesizer fields and scale
`define ACG_R_MSB 3
`define ACG_P_MSB 6
`define ACG_P_LSB 4
`define ACG_J_MSB 5
`define ACG_DHI_MSB 5
`define ACG_R_MAX 5'h10
`define ACG_P_MAX 4'h8
`define ACG_FRAC_SCALE 20'h02710
`define ACG_HALF_SCALE 25'h0001388

// Output selectors
`define ACG_BSEL_MSB 6
`define ACG_BSEL_LSB 4
`define ACG_FSEL_MSB 2
`define ACG_BSEL_CNT 3'h5
`define ACG_FSEL_CNT 3'h7
`define ACG_RSEL_MSB 1
`define ACG_GSEL_MSB 3
`define ACG_GSEL_CNT 4'h8

// Pin clock-output codes
`define ACG_PCODE_A 4'h3
`define ACG_PCODE_B 4'h4
`define ACG_PCODE_C 5'h04

// Pin function field positions
`define ACG_PA_MSB 4
`define ACG_PA_LSB 1
`define ACG_PB_MSB 5
`define ACG_PB_LSB 2
`define ACG_PC_MSB 6
`define ACG_PC_LSB 2
`define ACG_NPIN 6

`endif

// >>> core/acg_pkg.sv
package acg_pkg;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } acgRegReq_s;

   typedef struct packed {
      logic pbRoot;
      logic pbMod;
      logic recRoot;
      logic recMod;
      logic pbSample;
      logic recSample;
      logic synthRef;
   } acgSrcClk_s;

   typedef struct packed {
      logic [2:0] bitClk;
      logic [2:0] frameClk;
   } acgPortClk_s;

   typedef struct packed {
      logic [5:0] level;
      logic [5:0] oe;
   } acgPinDrv_s;

endpackage

// >>> core/acg_clock_gen.sv
`timescale 1ns/100ps
`include "acg_regs.svh"
// Overview of operation
// - Bit dividers divide source by 1..128, enabled
// - Two-bit field picks bit-divider root source
// - Frame dividers divide bit clock 32..128
// - Port 1 frame output chosen from seven
// - Port 2 frame output chosen from seven
// - Port 3 frame output chosen from seven
// - Bit output chosen from dividers or peers
// - Pin codes route general clock onto pins
// - General clock divides selected source 1..128
// - Synth output equals ref*R*J.D/(P*pre)
// - R field low nibble, 1..16, reset 1
// - P field bits 6:4, 1..8, reset 1
// - J field six bits, 1..63, reset 4
// - D split high/low registers, reset zero
// - Reference predivider seven bits, reset 1
// - Synth enabled alone, feeds general selector
// - New D applies on low register write
module acg_clock_gen
   import acg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // Register port
   input wire acgRegReq_s regReq,
   output logic [7:0] regRdData,
   output logic regRdValid,
   // Source clocks
   input wire acgSrcClk_s srcClk,
   // Serial port clocks
   input wire acgPortClk_s portClkIn,
   output acgPortClk_s portClkOut,
   // Generated clocks
   output logic generalClkOut,
   output logic synthClkOut,
   // Pin drive
   output acgPinDrv_s pinDrv
);

   localparam int NDIV = 7;
   localparam int GDIV = 6;

   ////////////////////////////////////////////////////////////////////
   // Register file

   logic [7:0] reg_q [`ACG_NREG];
   logic [7:0] regRdData_q;
   logic regRdValid_q;

   function automatic logic [5:0] slotOf(input logic [6:0] a);
      // Bit 5 flags a mapped address, low bits the slot
      unique case (a)
         `ACG_OFF_SYN_EPR: slotOf = 6'h20;
         `ACG_OFF_SYN_J: slotOf = 6'h21;
         `ACG_OFF_SYN_DHI: slotOf = 6'h22;
         `ACG_OFF_SYN_DLO: slotOf = 6'h23;
         `ACG_OFF_SYN_PRE: slotOf = 6'h24;
         `ACG_OFF_P1_BSRC: slotOf = 6'h25;
         `ACG_OFF_P1_BDIV: slotOf = 6'h26;
         `ACG_OFF_P1_FDIV: slotOf = 6'h27;
         `ACG_OFF_P1_OSEL: slotOf = 6'h28;
         `ACG_OFF_GP_SRC: slotOf = 6'h29;
         `ACG_OFF_GP_DIV: slotOf = 6'h2A;
         `ACG_OFF_P2_BSRC: slotOf = 6'h2B;
         `ACG_OFF_P2_BDIV: slotOf = 6'h2C;
         `ACG_OFF_P2_FDIV: slotOf = 6'h2D;
         `ACG_OFF_P2_OSEL: slotOf = 6'h2E;
         `ACG_OFF_P3_BSRC: slotOf = 6'h2F;
         `ACG_OFF_P3_BDIV: slotOf = 6'h30;
         `ACG_OFF_P3_FDIV: slotOf = 6'h31;
         `ACG_OFF_P3_OSEL: slotOf = 6'h32;
         `ACG_OFF_PIN_PORT1_DATA_OUT_PIN: slotOf = 6'h33;
         `ACG_OFF_PIN_FRM2: slotOf = 6'h34;
         `ACG_OFF_PIN_BIT2: slotOf = 6'h35;
         `ACG_OFF_PIN_GP_IO_PIN_ONE: slotOf = 6'h36;
         `ACG_OFF_PIN_GP_IO_PIN_TWO: slotOf = 6'h37;
         `ACG_OFF_PIN_GP_OUTPUT_PIN_ONE: slotOf = 6'h38;
         default: slotOf = 6'h00;
      endcase
   endfunction

   function automatic logic [7:0] rstOf(input int s);
      unique case (s)
         `ACG_IX_SYN_EPR: rstOf = `ACG_RST_SYN_EPR;
         `ACG_IX_SYN_J: rstOf = `ACG_RST_SYN_J;
         `ACG_IX_SYN_PRE: rstOf = `ACG_RST_SYN_PRE;
         default: rstOf = `ACG_RST_ZERO;
      endcase
   endfunction

   wire [5:0] slot = slotOf(regReq.addr);
   wire hit = slot[5];
   wire [4:0] slotIx = slot[4:0];
   wire wrHit = ce & regReq.wr & hit;
   wire rdNow = ce & regReq.rd;
   wire [7:0] rdWord = hit ? reg_q[slotIx] : `ACG_RST_ZERO;

   for (genvar e = 0; e < `ACG_NREG; e++) begin : gReg
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            reg_q[e] <= rstOf(e);
         end else if (wrHit && slotIx == 5'(e)) begin
            reg_q[e] <= regReq.wdata;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         regRdData_q <= `ACG_RST_ZERO;
         regRdValid_q <= 1'b0;
      end else if (ce) begin
         regRdData_q <= rdNow ? rdWord : regRdData_q;
         regRdValid_q <= rdNow;
      end
   end

   assign regRdData = regRdData_q;
   assign regRdValid = regRdValid_q;

   ////////////////////////////////////////////////////////////////////
   // Ratio decode

   function automatic logic [7:0] ratioOf(input logic [6:0] f);
      ratioOf = (f == 7'h00) ? `ACG_DIV_MAX : {1'b0, f};
   endfunction

   function automatic logic [7:0] frameRatioOf(input logic [6:0] f);
      logic [7:0] r;
      r = ratioOf(f);
      frameRatioOf = (r < `ACG_FDIV_MIN) ? `ACG_FDIV_MIN : r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Synthesizer

   logic [13:0] fracLive_q;
   logic [27:0] synAcc_q;
   logic synRefPrev_q;
   logic synOut_q;

   wire [7:0] synEpr = reg_q[`ACG_IX_SYN_EPR];
   wire synEn = synEpr[`ACG_EN_BIT];
   wire [3:0] rFld = synEpr[`ACG_R_MSB:0];
   wire [2:0] pFld = synEpr[`ACG_P_MSB:`ACG_P_LSB];
   wire [5:0] jFld = reg_q[`ACG_IX_SYN_J][`ACG_J_MSB:0];
   wire [6:0] preFld = reg_q[`ACG_IX_SYN_PRE][`ACG_RATIO_MSB:0];

   // Zero codes stand for the top of each range
   wire [4:0] rVal = (rFld == 4'h0) ? `ACG_R_MAX : {1'b0, rFld};
   wire [3:0] pVal = (pFld == 3'h0) ? `ACG_P_MAX : {1'b0, pFld};
   wire [7:0] preVal = ratioOf(preFld);

   // J.D scaled by the fraction base
   wire [19:0] jdVal = 20'({14'h0000, jFld} * `ACG_FRAC_SCALE
                           + {6'h00, fracLive_q});
   wire [24:0] synInc = 25'({20'h00000, rVal} * jdVal);
   wire [24:0] synHalf = 25'({4'h0, pVal} * {4'h0, preVal}
                             * `ACG_HALF_SCALE);

   wire synRefRise = srcClk.synthRef & ~synRefPrev_q;
   wire [27:0] synSum = synAcc_q
                      + {3'h0, synRefRise ? synInc : 25'h0000000};
   wire synStep = synSum >= {3'h0, synHalf};
   wire [27:0] synAcc_d = synStep ? synSum - {3'h0, synHalf} : synSum;

   // High register is staged; the pair takes effect with the low byte
   wire loWrite = wrHit && slotIx == 5'(`ACG_IX_SYN_DLO);
   wire [13:0] fracNew = {reg_q[`ACG_IX_SYN_DHI][`ACG_DHI_MSB:0],
                          regReq.wdata};

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fracLive_q <= 14'h0000;
      end else if (loWrite) begin
         fracLive_q <= fracNew;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         synAcc_q <= 28'h0000000;
         synOut_q <= 1'b0;
         synRefPrev_q <= 1'b0;
      end else if (ce) begin
         synRefPrev_q <= srcClk.synthRef;
         // Each half period toggles the output
         synAcc_q <= synEn ? synAcc_d : 28'h0000000;
         synOut_q <= synEn & (synOut_q ^ synStep);
      end
   end

   assign synthClkOut = synOut_q;

   ////////////////////////////////////////////////////////////////////
   // Dividers: 0..2 bit, 3..5 frame, 6 general

   logic [NDIV-1:0] divSrc;
   logic [NDIV-1:0] divEn;
   logic [7:0] divRatio [NDIV];
   logic [NDIV-1:0] divSrcPrev_q;
   logic [NDIV-1:0] divOut_q;
   acgPortClk_s portClk_q;

   wire [3:0] rootCand = {srcClk.recMod, srcClk.recRoot,
                          srcClk.pbMod, srcClk.pbRoot};

   for (genvar k = 0; k < NDIV; k++) begin : gDiv
      logic [7:0] pos_q;
      wire rise = divSrc[k] & ~divSrcPrev_q[k];
      wire [7:0] posNext = (pos_q == divRatio[k]) ? `ACG_ONE
                                                  : pos_q + `ACG_ONE;
      // Idle at zero until the first source edge after enable
      wire [7:0] pos_d = !divEn[k] ? `ACG_RST_ZERO
                       : rise ? posNext : pos_q;
      wire highPhase = pos_d != `ACG_RST_ZERO
                     && pos_d <= (divRatio[k] >> 1);
      wire out_d = divEn[k] & ((divRatio[k] == `ACG_ONE)
                   ? divSrc[k] : highPhase);

      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            pos_q <= `ACG_RST_ZERO;
            divOut_q[k] <= 1'b0;
            divSrcPrev_q[k] <= 1'b0;
         end else if (ce) begin
            pos_q <= pos_d;
            divOut_q[k] <= out_d;
            divSrcPrev_q[k] <= divSrc[k];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Per-port selection

   localparam int BSRC_IX [3] = '{5, 11, 15};
   localparam int BDIV_IX [3] = '{6, 12, 16};
   localparam int FDIV_IX [3] = '{7, 13, 17};
   localparam int OSEL_IX [3] = '{8, 14, 18};

   for (genvar i = 0; i < 3; i++) begin : gPort
      localparam int OA = (i == 0) ? 1 : 0;
      localparam int OB = (i == 2) ? 1 : 2;
      wire [7:0] bsrc = reg_q[BSRC_IX[i]];
      wire [7:0] bdiv = reg_q[BDIV_IX[i]];
      wire [7:0] fdiv = reg_q[FDIV_IX[i]];
      wire [7:0] osel = reg_q[OSEL_IX[i]];
      wire [1:0] rootSel = bsrc[`ACG_RSEL_MSB:0];
      wire [2:0] bitSel = osel[`ACG_BSEL_MSB:`ACG_BSEL_LSB];
      wire [2:0] frameSel = osel[`ACG_FSEL_MSB:0];
      wire [4:0] bitCand = {portClkIn.bitClk[OB],
                            portClkIn.bitClk[OA], divOut_q[2:0]};
      wire [6:0] frameCand = {portClkIn.frameClk[OB],
                              portClkIn.frameClk[OA], divOut_q[5:3],
                              srcClk.recSample, srcClk.pbSample};
      wire bitNext = (bitSel < `ACG_BSEL_CNT)
                   & bitCand[bitSel];
      wire frameNext = (frameSel < `ACG_FSEL_CNT)
                     & frameCand[frameSel];

      assign divSrc[i] = rootCand[rootSel];
      assign divEn[i] = bdiv[`ACG_EN_BIT];
      assign divRatio[i] = ratioOf(bdiv[`ACG_RATIO_MSB:0]);
      assign divSrc[3 + i] = portClk_q.bitClk[i];
      assign divEn[3 + i] = fdiv[`ACG_EN_BIT];
      assign divRatio[3 + i] =
         frameRatioOf(fdiv[`ACG_RATIO_MSB:0]);

      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            portClk_q.bitClk[i] <= 1'b0;
            portClk_q.frameClk[i] <= 1'b0;
         end else if (ce) begin
            portClk_q.bitClk[i] <= bitNext;
            portClk_q.frameClk[i] <= frameNext;
         end
      end
   end

   assign portClkOut = portClk_q;

   ////////////////////////////////////////////////////////////////////
   // General clock output

   wire [3:0] genSel = reg_q[`ACG_IX_GP_SRC][`ACG_GSEL_MSB:0];
   wire [7:0] genDiv = reg_q[`ACG_IX_GP_DIV];
   wire [7:0] genCand = {srcClk.recSample, srcClk.pbSample,
                         srcClk.synthRef, synOut_q, rootCand};

   assign divSrc[GDIV] = (genSel < `ACG_GSEL_CNT)
                       & genCand[genSel[2:0]];
   assign divEn[GDIV] = genDiv[`ACG_EN_BIT];
   assign divRatio[GDIV] = ratioOf(genDiv[`ACG_RATIO_MSB:0]);
   assign generalClkOut = divOut_q[GDIV];

   ////////////////////////////////////////////////////////////////////
   // Pin routing: port1_data_out_pin, frame2, bit2, gp_io_pin_one, gp_io_pin_two, gp_output_pin_one

   logic [5:0] pinMatch;
   acgPinDrv_s pinDrv_q;

   wire [7:0] pinFn [`ACG_NPIN];

   // Function bytes of the six clock-capable pins, in slot order
   for (genvar q = 0; q < `ACG_NPIN; q++) begin : gPinFn
      assign pinFn[q] = reg_q[`ACG_IX_PIN0 + q];
   end

   // Each pin family keeps its code in a different field
   assign pinMatch[0] = pinFn[0][`ACG_PA_MSB:`ACG_PA_LSB] == `ACG_PCODE_A;
   assign pinMatch[1] = pinFn[1][`ACG_PB_MSB:`ACG_PB_LSB] == `ACG_PCODE_B;
   assign pinMatch[2] = pinFn[2][`ACG_PB_MSB:`ACG_PB_LSB] == `ACG_PCODE_B;
   assign pinMatch[3] = pinFn[3][`ACG_PC_MSB:`ACG_PC_LSB] == `ACG_PCODE_C;
   assign pinMatch[4] = pinFn[4][`ACG_PC_MSB:`ACG_PC_LSB] == `ACG_PCODE_C;
   assign pinMatch[5] = pinFn[5][`ACG_PA_MSB:`ACG_PA_LSB] == `ACG_PCODE_A;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pinDrv_q <= '0;
      end else if (ce) begin
         // A pin not set to the clock code is released, low
         pinDrv_q.oe <= pinMatch;
         pinDrv_q.level <= pinMatch & {6{divOut_q[GDIV]}};
      end
   end

   assign pinDrv = pinDrv_q;

endmodule

// >>> testbench/acg_clock_gen_props.sv
`timescale 1ns/100ps
module acg_clock_props
   import acg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // Register port
   input wire acgRegReq_s regReq,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   // Clocks
   input wire acgSrcClk_s srcClk,
   input wire acgPortClk_s portClkIn,
   input wire acgPortClk_s portClkOut,
   input wire logic generalClkOut,
   input wire logic synthClkOut,
   input wire acgPinDrv_s pinDrv
);
   logic [2:0] bitSel_q;
   logic gpEn_q;
   logic synEn_q;
   ////////////////////////////////////////////////////////////////////////
   // Shadow of the control bits that silence outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bitSel_q <= 3'h0;
         gpEn_q <= 1'b0;
         synEn_q <= 1'b0;
      end else if (ce && regReq.wr) begin
         case (regReq.addr)
            7'h06: synEn_q <= regReq.wdata[7];
            7'h0E: bitSel_q <= regReq.wdata[6:4];
            7'h16: gpEn_q <= regReq.wdata[7];
            default: ;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   sequence s_rd_taken;
      ce && regReq.rd;
   endsequence
   sequence s_pin_live;
      ce ##1 pinDrv.oe[0];
   endsequence
   property p_rd_valid;
      s_rd_taken |=> regRdValid;
   endproperty
   a_rd_valid: assert property (p_rd_valid)
      else $error("read answer missing");
   property p_rd_idle;
      ce && !regReq.rd |=> !regRdValid && $stable(regRdData);
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read port moved without a read");
   property p_reset_out;
      $rose(rst_b) |-> {portClkOut, generalClkOut, synthClkOut, pinDrv} == '0;
   endproperty
   a_reset_out: assert property (p_reset_out)
      else $error("outputs not low after reset");
   property p_pin_idle;
      (pinDrv.level & ~pinDrv.oe) == 6'h00;
   endproperty
   a_pin_idle: assert property (p_pin_idle)
      else $error("undriven pin level high");
   property p_pin_follow;
      s_pin_live |-> pinDrv.level == (pinDrv.oe & {6{$past(generalClkOut)}});
   endproperty
   a_pin_follow: assert property (p_pin_follow)
      else $error("pin does not carry general clock");
   property p_bsel_void;
      ce && bitSel_q >= 3'h5 |=> portClkOut.bitClk[0] == 1'b0;
   endproperty
   a_bsel_void: assert property (p_bsel_void)
      else $error("void bit selector not low");
   property p_gp_off;
      ce && !gpEn_q |=> !generalClkOut;
   endproperty
   a_gp_off: assert property (p_gp_off)
      else $error("general clock runs while disabled");
   property p_syn_off;
      ce && !synEn_q |=> !synthClkOut;
   endproperty
   a_syn_off: assert property (p_syn_off)
      else $error("synth runs while disabled");
endmodule

bind acg_clock_gen acg_clock_props i_acg_clock_props (
   .clk(clk), .rst_b(rst_b), .ce(ce), .regReq(regReq),
   .regRdData(regRdData), .regRdValid(regRdValid), .srcClk(srcClk),
   .portClkIn(portClkIn), .portClkOut(portClkOut),
   .generalClkOut(generalClkOut), .synthClkOut(synthClkOut),
   .pinDrv(pinDrv)
);

// >>> testbench/acg_peer_model.sv
`timescale 1ns/100ps
module acg_peer_model
   import acg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Frame activity
   input wire logic run,
   // Clocks toward the device
   output acgPortClk_s peerClk
);
   logic [4:0] peerCnt_q;
   logic [4:0] peerCnt_d;
   // Peer clocks stand still while no frames run
   assign peerCnt_d = run ? peerCnt_q + 5'h01 : 5'h00;
   assign peerClk = {peerCnt_q[3:1], peerCnt_q[4:2]};
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         peerCnt_q <= 5'h00;
      end else begin
         peerCnt_q <= peerCnt_d;
      end
   end
endmodule

// >>> testbench/tb.sv
`timescale 1ns/100ps
module tb;
   import acg_pkg::*;
   logic clk;
   logic rst_b;
   logic ce;
   acgRegReq_s regReq;
   logic [7:0] regRdData;
   logic regRdValid;
   acgSrcClk_s srcClk;
   acgPortClk_s portClkIn;
   acgPortClk_s portClkOut;
   logic generalClkOut;
   logic synthClkOut;
   acgPinDrv_s pinDrv;
   logic peerRun;
   logic [8:0] watch;
   int cyc = 0;
   int n_mismatch;
   int checks_done;
   logic [6:0] oselOff [3] = '{7'h0E, 7'h1E, 7'h2E};
   assign watch = {pinDrv.level[0], synthClkOut, generalClkOut,
                   portClkOut.frameClk, portClkOut.bitClk};
   acg_clock_gen i_acg_clock_gen (
      .clk(clk), .rst_b(rst_b), .ce(ce), .regReq(regReq),
      .regRdData(regRdData), .regRdValid(regRdValid), .srcClk(srcClk),
      .portClkIn(portClkIn), .portClkOut(portClkOut),
      .generalClkOut(generalClkOut), .synthClkOut(synthClkOut),
      .pinDrv(pinDrv)
   );
   acg_peer_model i_acg_peer_model (
      .clk(clk), .rst_b(rst_b), .run(peerRun), .peerClk(portClkIn)
   );
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   function automatic logic half(input int h);
      return ((cyc / h) % 2) == 1;
   endfunction
   // Source clocks with distinct half periods
   always @(posedge clk) begin
      #1;
      cyc = cyc + 1;
      srcClk = {half(1), half(2), half(3), half(4), half(5), half(7), half(6)};
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] got,
                        input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      regReq = {1'b1, 1'b0, a, d};
      @(posedge clk);
      #1 regReq = '0;
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      regReq = {1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      #1 regReq = '0;
      d = regRdData;
      check("read valid", regRdValid, 1'b1);
      @(posedge clk);
      #1;
   endtask
   // Count rising edges of one watched output over a window
   task automatic near(input string nm, input int idx, input int w,
                       input int e);
      int n;
      logic prev;
      n = 0;
      repeat (64) @(posedge clk);
      #1 prev = watch[idx];
      repeat (w) begin
         @(posedge clk);
         #1;
         if (watch[idx] === 1'b1 && prev === 1'b0) n++;
         prev = watch[idx];
      end
      check(nm, ((e == 0) ? n == 0 : (n >= e - 1 && n <= e + 1)) ? e : n, e);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [6:0] a [7] = '{7'h06, 7'h07, 7'h0A, 7'h08, 7'h2E, 7'h60, 7'h00};
      logic [7:0] e [7] = '{8'h11, 8'h04, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
      logic [7:0] d;
      wr(7'h00, 8'h5A);
      for (int i = 0; i < 7; i++) begin
         rd(a[i], d);
         check("reset value", d, e[i]);
      end
      ce = 1'b0;
      wr(7'h07, 8'h3F);
      ce = 1'b1;
      rd(7'h07, d);
      check("frozen write", d, 8'h04);
      wr(7'h08, 8'h13);
      rd(7'h08, d);
      check("fraction high", d, 8'h13);
   endtask
   task automatic t_bits();
      int per;
      for (int s = 0; s < 4; s++) begin
         wr(7'h0B, 8'(s));
         wr(7'h0C, 8'h83);
         near("bit divider", 0, 600, 600 / (6 * (s + 1)));
      end
      wr(7'h0B, 8'h00);
      wr(7'h0C, 8'h80);
      near("bit ratio 128", 0, 1280, 5);
      wr(7'h0C, 8'h03);
      near("bit disabled", 0, 600, 0);
      wr(7'h0C, 8'h81);
      wr(7'h1C, 8'h83);
      wr(7'h2C, 8'h85);
      for (int p = 0; p < 3; p++) begin
         for (int c = 0; c < 6; c++) begin
            wr(oselOff[p], {1'b0, 3'(c), 4'h0});
            per = c < 3 ? 4 * c + 2 : 4 << (c == 3 ? (p == 0 ? 1 : 0)
                                               : (p == 2 ? 1 : 2));
            near("bit select", p, 600, c == 5 ? 0 : 600 / per);
         end
      end
   endtask
   task automatic t_frames();
      int per [8] = '{10, 14, 64, 192, 640, 0, 0, 0};
      wr(7'h0D, 8'hA0);
      wr(7'h1D, 8'h85);
      wr(7'h2D, 8'hC0);
      for (int p = 0; p < 3; p++) begin
         wr(oselOff[p], {1'b0, 3'(p), 4'h7});
      end
      for (int p = 0; p < 3; p++) begin
         per[5] = 8 << (p == 0 ? 1 : 0);
         per[6] = 8 << (p == 2 ? 1 : 2);
         for (int c = 0; c < 8; c++) begin
            wr(oselOff[p], {1'b0, 3'(p), 1'b0, 3'(c)});
            near("frame select", 3 + p, 1536,
                 c == 7 ? 0 : 1536 / per[c]);
         end
      end
   endtask
   task automatic t_general();
      int per [9] = '{2, 4, 6, 8, 3, 12, 10, 14, 0};
      logic [6:0] pa [6] = '{7'h43, 7'h45, 7'h46, 7'h56, 7'h57, 7'h60};
      logic [7:0] pv [6] = '{8'h06, 8'h10, 8'h10, 8'h10, 8'h10, 8'h06};
      wr(7'h06, 8'h91);
      wr(7'h16, 8'h82);
      for (int g = 0; g < 9; g++) begin
         wr(7'h15, 8'(g));
         near("general source", 6, 1200,
              g == 8 ? 0 : 600 / per[g]);
      end
      wr(7'h15, 8'h00);
      for (int i = 0; i < 6; i++) begin
         wr(pa[i], pv[i]);
      end
      check("pin enables", pinDrv.oe, 6'h3F);
      near("pin clock", 8, 600, 150);
      wr(7'h43, 8'h08);
      check("pin enable off", pinDrv.oe, 6'h3E);
      wr(7'h16, 8'h02);
      near("general disabled", 6, 600, 0);
   endtask
   task automatic t_synth();
      logic [39:0] cfg [7] = '{40'h91_04_00_00_01, 40'hA2_03_00_00_01,
         40'h80_01_00_00_02, 40'h91_03_00_00_06, 40'h91_3F_00_00_00,
         40'h11_04_00_00_01, 40'h92_01_13_88_01};
      int e [7] = '{400, 300, 100, 50, 49, 0, 300};
      for (int i = 0; i < 7; i++) begin
         for (int r = 0; r < 5; r++) begin
            wr(7'h06 + 7'(r), cfg[i][39 - 8 * r -: 8]);
         end
         near("synth rate", 7, 1200, e[i]);
      end
      wr(7'h08, 8'h00);
      near("fraction staged", 7, 1200, 300);
      wr(7'h09, 8'h00);
      near("fraction loaded", 7, 1200, 200);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_b = 1'b0;
      ce = 1'b1;
      regReq = '0;
      peerRun = 1'b0;
      n_mismatch = 0;
      checks_done = 0;
      repeat (20) @(posedge clk);
      #1 rst_b = 1'b1;
      peerRun = 1'b1;
      t_regs();
      t_bits();
      t_frames();
      t_general();
      t_synth();
      stop_test();
   end
endmodule
